// ### fpd_core.sv
// lock, deep power-down and resume command handling
//
// Functional notes
// - lock opcode, eight bits MSB first
// - lock needs 4Dh then 67h
// - release off byte boundary aborts command
// - sleep opcode enters deep only if select set
// - deep sleep honours only resume and reset
// - sleep opcode is command only
// - deep sleep reached within entry time
// - sleep opcode ignored while busy
// - resume released at eighth clock exits
// - resume with dummies shifts identifier out
// - identifier repeats while select held
// - resume acts by power state
// - deepest exit resets, ready within time
// - deepest entry and resume-only behaviour
// - lock refused while write enable clear
// - lock needs both protect bits set
`timescale 1ns/1ps
module fpd_core (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // serial pins
  input wire fpd_pkg::fpd_spi_t spi_in,
  output logic so_out,
  output logic so_oe_out,
  // device status
  input wire fpd_pkg::fpd_status_t status_in,
  // results
  output logic status_lock_out,
  output logic deep_sleep_state_out,
  output logic deepest_sleep_state_out,
  output logic standby_ready_out,
  output logic internal_reset_out,
  output logic reset_cmd_out
);
  import fpd_pkg::*;

  // pins come from the host clock domain
  fpd_spi_t spi_s1, spi_s2, spi_s3;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      spi_s1 <= 3'h4;
      spi_s2 <= 3'h4;
      spi_s3 <= 3'h4;
    end else begin
      spi_s1 <= spi_in;
      spi_s2 <= spi_s1;
      spi_s3 <= spi_s2;
    end
  end

  logic sel, cs_fall, cs_rise, sck_rise, sck_fall;
  assign sel = !spi_s2.cs_n;
  assign cs_fall = spi_s3.cs_n && !spi_s2.cs_n;
  assign cs_rise = !spi_s3.cs_n && spi_s2.cs_n;
  assign sck_rise = sel && !spi_s3.sck && spi_s2.sck;
  assign sck_fall = sel && spi_s3.sck && !spi_s2.sck;

  // frame capture
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [2:0] byte_cnt, next_byte_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] opcode, next_opcode;
  logic [7:0] verify1, next_verify1;
  logic [7:0] verify2, next_verify2;
  logic so, next_so, so_oe, next_so_oe;
  fpd_state_t state, next_state;
  logic id_phase;

  function automatic logic frame_is(input logic [7:0] op_seen,
                                    input logic [2:0] len_seen,
                                    input logic [7:0] op,
                                    input logic [2:0] len);
    frame_is = (op_seen == op) && (len_seen == len);
  endfunction

  // identifier only while standby or deep sleep
  assign id_phase = (opcode == OP_RESUME) && (byte_cnt >= LEN_ID_START) &&
                    (state == ST_STANDBY || state == ST_DEEP);

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_shift = shift;
    next_opcode = opcode;
    next_verify1 = verify1;
    next_verify2 = verify2;
    next_so = so;
    next_so_oe = so_oe;
    if (cs_fall) begin
      next_bit_cnt = 3'h0;
      next_byte_cnt = 3'h0;
      next_opcode = 8'h00;
    end else if (sck_rise) begin
      next_shift = {shift[6:0], spi_s2.si};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == BIT_LAST) begin
        unique case (byte_cnt)
          3'h0: next_opcode = next_shift;
          3'h1: next_verify1 = next_shift;
          3'h2: next_verify2 = next_shift;
          default: ;
        endcase
        if (byte_cnt != LEN_SAT)
          next_byte_cnt = byte_cnt + 3'h1;
      end
    end
    if (sck_fall && id_phase && !cs_fall) begin
      next_so = DEVICE_ID[~bit_cnt];
      next_so_oe = 1'b1;
    end
    if (!sel)
      next_so_oe = 1'b0;
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      shift <= 8'h00;
      opcode <= 8'h00;
      verify1 <= 8'h00;
      verify2 <= 8'h00;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      shift <= next_shift;
      opcode <= next_opcode;
      verify1 <= next_verify1;
      verify2 <= next_verify2;
      so <= next_so;
      so_oe <= next_so_oe;
    end
  end
  assign so_out = so;
  assign so_oe_out = so_oe;

  // power state and lock
  logic [TIMER_W-1:0] timer, next_timer;
  logic lock, next_lock, rst_p, next_rst_p, rcmd, next_rcmd;
  logic whole, lock_ok, sleep_ok;

  assign whole = cs_rise && (bit_cnt == 3'h0);
  assign lock_ok = frame_is(opcode, byte_cnt, OP_LOCK, LEN_LOCK) &&
                   verify1 == LOCK_VERIFY_FIRST &&
                   verify2 == LOCK_VERIFY_SECOND &&
                   status_in.write_enable_latch &&
                   status_in.status_protect_high &&
                   status_in.status_protect_low;
  assign sleep_ok = !status_in.device_busy_flag &&
                    frame_is(opcode, byte_cnt, OP_SLEEP, LEN_CMD_ONLY);

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_lock = lock;
    next_rst_p = 1'b0;
    next_rcmd = 1'b0;
    if (timer != '0)
      next_timer = timer - TIMER_W'(1);
    unique case (state)
      ST_STANDBY: if (whole) begin
        if (lock_ok)
          next_lock = 1'b1;
        else if (sleep_ok && status_in.power_down_depth_select) begin
          next_state = ST_ENTER_DEEP;
          next_timer = SLEEP_ENTRY_CYC - TIMER_W'(1);
        end else if (sleep_ok || (!status_in.device_busy_flag &&
                 frame_is(opcode, byte_cnt, OP_DEEPEST, LEN_CMD_ONLY))) begin
          next_state = ST_ENTER_DEEPEST;
          next_timer = SLEEP_ENTRY_CYC - TIMER_W'(1);
        end
      end
      ST_ENTER_DEEP: if (timer == '0) next_state = ST_DEEP;
      // deep exit, with or without id
      ST_DEEP: if (whole) begin
        if (opcode == OP_RESUME && byte_cnt != 3'h0) begin
          next_state = ST_EXIT_DEEP;
          next_timer = SLEEP_EXIT_CYC - TIMER_W'(1);
        end else if (frame_is(opcode, byte_cnt, OP_RESET_EN, LEN_CMD_ONLY) ||
                     frame_is(opcode, byte_cnt, OP_RESET, LEN_CMD_ONLY))
          next_rcmd = 1'b1;
      end
      ST_EXIT_DEEP: if (timer == '0) next_state = ST_STANDBY;
      ST_ENTER_DEEPEST: if (timer == '0) next_state = ST_DEEPEST;
      ST_DEEPEST: if (whole &&
                      frame_is(opcode, byte_cnt, OP_RESUME, LEN_CMD_ONLY)) begin
        next_state = ST_EXIT_DEEPEST;
        next_timer = DEEPEST_EXIT_CYC - TIMER_W'(1);
        next_rst_p = 1'b1;
        next_lock = 1'b0;
      end
      ST_EXIT_DEEPEST: if (timer == '0) next_state = ST_STANDBY;
      default: next_state = ST_STANDBY;
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_STANDBY;
      timer <= '0;
      lock <= 1'b0;
      rst_p <= 1'b0;
      rcmd <= 1'b0;
      deep_sleep_state_out <= 1'b0;
      deepest_sleep_state_out <= 1'b0;
      standby_ready_out <= 1'b1;
    end else begin
      state <= next_state;
      timer <= next_timer;
      lock <= next_lock;
      rst_p <= next_rst_p;
      rcmd <= next_rcmd;
      deep_sleep_state_out <= next_state == ST_DEEP;
      deepest_sleep_state_out <= next_state == ST_DEEPEST;
      standby_ready_out <= next_state == ST_STANDBY;
    end
  end
  assign status_lock_out = lock;
  assign internal_reset_out = rst_p;
  assign reset_cmd_out = rcmd;

  // checks
  localparam int A_ENTRY = 302;
  localparam int A_EXIT = 802;
  localparam int A_DEEPEST = 902;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  sequence s_enter_deep;
    $rose(state == ST_ENTER_DEEP);
  endsequence
  sequence s_id_shift;
    sck_fall && id_phase && !cs_fall;
  endsequence

  a_lock_verified: assert property (
    $rose(lock) |-> $past(verify1 == LOCK_VERIFY_FIRST &&
      verify2 == LOCK_VERIFY_SECOND && status_in.write_enable_latch &&
      status_in.status_protect_high && status_in.status_protect_low))
    else $error("lock set without verified frame");
  a_deep_select: assert property (
    s_enter_deep |-> $past(status_in.power_down_depth_select))
    else $error("deep sleep entered with select clear");
  a_busy_blocks: assert property (
    $rose(state == ST_ENTER_DEEP || state == ST_ENTER_DEEPEST)
    |-> !$past(status_in.device_busy_flag))
    else $error("sleep entered while busy");
  a_entry_time: assert property (
    s_enter_deep |-> ##[1:A_ENTRY] deep_sleep_state_out)
    else $error("deep sleep entry too slow");
  a_exit_time: assert property (
    $rose(state == ST_EXIT_DEEP) |-> ##[1:A_EXIT] standby_ready_out)
    else $error("deep sleep exit too slow");
  a_partial_abort: assert property (
    cs_rise && bit_cnt != 3'h0 |=> $stable(state) && $stable(lock))
    else $error("partial frame acted on");
  a_deep_ignores: assert property (
    state == ST_DEEP && cs_rise && opcode != OP_RESUME |=> state == ST_DEEP)
    else $error("deep sleep left on wrong opcode");
  a_id_repeat: assert property (
    s_id_shift |=> so_out == DEVICE_ID[~$past(bit_cnt)] && so_oe_out)
    else $error("identifier bit wrong");
  a_deepest_exit: assert property (
    $rose(state == ST_EXIT_DEEPEST) |-> internal_reset_out && !lock
    ##[1:A_DEEPEST] standby_ready_out)
    else $error("deepest exit sequence wrong");
endmodule // fpd_core

// ### fpd_pkg.sv
// constants and carrier types for the lock and power-down command block
package fpd_pkg;

  // clock and timing, times in ns
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEEP_ENTRY_TIME_NS = 3000;
  localparam int SLEEP_EXIT_TIME_NS = 8000;
  localparam int DEEPEST_SLEEP_EXIT_TIME_NS = 9000;
  localparam int TIMER_W = 10;
  // longest times round down to whole cycles
  localparam logic [TIMER_W-1:0] SLEEP_ENTRY_CYC =
    TIMER_W'(SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] SLEEP_EXIT_CYC =
    TIMER_W'(SLEEP_EXIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] DEEPEST_EXIT_CYC =
    TIMER_W'(DEEPEST_SLEEP_EXIT_TIME_NS / CLK_PERIOD_NS);

  // opcodes
  localparam logic [7:0] OP_LOCK = 8'h6F;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_DEEPEST = 8'h79;
  localparam logic [7:0] OP_RESUME = 8'hAB;
  localparam logic [7:0] OP_RESET_EN = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;

  // lock verification bytes
  localparam logic [7:0] LOCK_VERIFY_FIRST = 8'h4D;
  localparam logic [7:0] LOCK_VERIFY_SECOND = 8'h67;

  // frame lengths in bytes
  localparam logic [2:0] LEN_CMD_ONLY = 3'h1;
  localparam logic [2:0] LEN_LOCK = 3'h3;
  localparam logic [2:0] LEN_ID_START = 3'h4;
  localparam logic [2:0] LEN_SAT = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // identifier byte, value arbitrary
  localparam logic [7:0] DEVICE_ID = 8'hA5;

  // serial pins as seen at the device
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } fpd_spi_t;

  // status bits from the rest of the device
  typedef struct packed {
    logic power_down_depth_select;
    logic device_busy_flag;
    logic write_enable_latch;
    logic status_protect_high;
    logic status_protect_low;
  } fpd_status_t;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_ENTER_DEEP,
    ST_DEEP,
    ST_EXIT_DEEP,
    ST_ENTER_DEEPEST,
    ST_DEEPEST,
    ST_EXIT_DEEPEST
  } fpd_state_t;

endpackage

// ### fpd_host_model.sv
// host serial controller model driving the command pins
`timescale 1ns/1ps
module fpd_host_model (
  // clock
  input wire logic clock_in,
  // serial pins
  input wire logic so_in,
  output fpd_pkg::fpd_spi_t spi_out
);
  import fpd_pkg::*;
  initial spi_out = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
  // phases of 5 clocks clear the synchroniser minimum of 3
  task automatic half();
    repeat (5) @(posedge clock_in);
    #1;
  endtask
  // msb first, whole frame before release
  task automatic xfer(input logic [63:0] bits, input int n,
                      input logic mode3, output logic [63:0] got);
    got = '0;
    spi_out.sck = mode3;
    half();
    spi_out.cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_out.sck = 1'b0;
      spi_out.si = bits[n-1-i];
      half();
      got = {got[62:0], so_in};
      spi_out.sck = 1'b1;
      half();
    end
    spi_out.sck = mode3;
    half();
    spi_out.cs_n = 1'b1;
    // released line shows the inverse, not a stale bit
    spi_out.si = ~spi_out.si;
    half();
    half();
  endtask
endmodule // fpd_host_model

// ### testbench.sv
// self-checking bench for the lock and power-down command block
`timescale 1ns/1ps
module testbench;
  import fpd_pkg::*;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  fpd_spi_t spi;
  fpd_status_t st = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic so, so_oe, lock, deep, deepest, ready, ireset, rcmd;
  logic [63:0] got;
  // released output shows the inverse of its last bit, so oe is tested too
  logic so_line;
  assign so_line = so_oe ? so : ~so;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_rcmd = 0;
  int n_ireset = 0;
  always #5 clock_in = ~clock_in;
  fpd_core i_fpd_core (.clock_in(clock_in), .resetn_in(resetn_in),
    .spi_in(spi), .so_out(so), .so_oe_out(so_oe), .status_in(st),
    .status_lock_out(lock), .deep_sleep_state_out(deep),
    .deepest_sleep_state_out(deepest), .standby_ready_out(ready),
    .internal_reset_out(ireset), .reset_cmd_out(rcmd));
  fpd_host_model i_fpd_host_model (.clock_in(clock_in), .so_in(so_line),
    .spi_out(spi));
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // pulses are counted so a missed single cycle still shows
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (rcmd === 1'b1) n_rcmd <= n_rcmd + 1;
    if (ireset === 1'b1) n_ireset <= n_ireset + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input logic a, input logic e, input string m);
    comparisons++;
    if (a !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic fr(input logic [63:0] b, input int n,
                    input logic m3 = 1'b0);
    i_fpd_host_model.xfer(b, n, m3, got);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic t_lock();
    st.write_enable_latch = 1'b0;
    fr({OP_LOCK, LOCK_VERIFY_FIRST, LOCK_VERIFY_SECOND}, 24);
    chk(lock, 1'b0, "lock without write enable");
    st.write_enable_latch = 1'b1;
    st.status_protect_low = 1'b0;
    fr({OP_LOCK, LOCK_VERIFY_FIRST, LOCK_VERIFY_SECOND}, 24);
    chk(lock, 1'b0, "lock with one protect bit");
    st.status_protect_low = 1'b1;
    fr({OP_LOCK, LOCK_VERIFY_SECOND, LOCK_VERIFY_FIRST}, 24);
    chk(lock, 1'b0, "lock with swapped verify");
    fr({OP_LOCK, LOCK_VERIFY_FIRST, LOCK_VERIFY_SECOND, 1'b0}, 25);
    chk(lock, 1'b0, "lock released off boundary");
    fr({OP_LOCK, LOCK_VERIFY_FIRST, LOCK_VERIFY_SECOND}, 24);
    chk(lock, 1'b1, "verified lock not taken");
    $display("test lock done");
  endtask
  task automatic t_sleep();
    st.device_busy_flag = 1'b1;
    fr(OP_SLEEP, 8);
    chk(ready, 1'b1, "sleep taken while busy");
    // busy seen clear before the retry
    st.device_busy_flag = 1'b0;
    fr({OP_SLEEP, 8'h00}, 16);
    chk(ready, 1'b1, "sleep taken with data byte");
    fr({OP_SLEEP, 1'b0}, 9);
    chk(ready, 1'b1, "sleep taken off boundary");
    fr(OP_SLEEP, 8);
    chk(ready, 1'b0, "sleep not started");
    wt(SLEEP_ENTRY_CYC);
    chk(deep, 1'b1, "deep sleep late");
    fr(OP_DEEPEST, 8);
    wt(SLEEP_ENTRY_CYC);
    chk(deepest, 1'b0, "opcode honoured in deep");
    fr(OP_RESET_EN, 8);
    fr(OP_RESET, 8);
    chk(n_rcmd == 2, 1'b1, "reset opcodes not seen");
    fr(OP_RESUME, 8, 1'b1);
    chk(ready, 1'b0, "exit too early");
    wt(SLEEP_EXIT_CYC);
    chk(ready & ~deep, 1'b1, "exit late in mode 3");
    $display("test sleep done");
  endtask
  task automatic t_ident();
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        fr(OP_SLEEP, 8);
        wt(SLEEP_ENTRY_CYC);
      end
      fr({OP_RESUME, 40'h0}, 48, k == 1);
      chk(got[15:0] === {DEVICE_ID, DEVICE_ID}, 1'b1, "id bits");
      chk(so_oe, 1'b0, "output not released");
      wt(SLEEP_EXIT_CYC);
      chk(ready & ~deep, 1'b1, "not back in standby");
    end
    $display("test ident done");
  endtask
  task automatic t_deepest();
    st.power_down_depth_select = 1'b0;
    fr(OP_SLEEP, 8);
    wt(SLEEP_ENTRY_CYC);
    chk(deepest & ~deep, 1'b1, "deepest not entered");
    st.power_down_depth_select = 1'b1;
    fr(OP_RESET_EN, 8);
    chk(n_rcmd == 2, 1'b1, "reset taken in deepest");
    fr(OP_RESUME, 8);
    chk(n_ireset == 1 && lock === 1'b0, 1'b1, "no internal reset");
    chk(ready, 1'b0, "deepest exit early");
    wt(DEEPEST_EXIT_CYC);
    chk(ready & ~deepest, 1'b1, "deepest exit late");
    fr(OP_DEEPEST, 8);
    wt(SLEEP_ENTRY_CYC);
    chk(deepest, 1'b1, "dedicated opcode ignored");
    $display("test deepest done");
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    #1;
    resetn_in = 1'b1;
    wt(2);
    chk(ready & ~lock & ~deep & ~deepest & ~so_oe, 1'b1, "reset values");
    t_lock();
    t_sleep();
    t_ident();
    t_deepest();
    finish_test();
  end
endmodule // testbench
